/* rtl/tcv_top.sv */
// top of the thread cell view decoder: apb slave, request sequencer with
// automatic retry of stalled requests, and the unit control register.
// assumes apb on the core clock; one request in flight at a time.
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
// How it works
// R1 - view chosen from address bits 6:3
// R2 - bypass: plain data access, no state change
// R3 - control view: access state word
// R4 - sync load on empty cell stalls
// R5 - last value read sets empty
// R6 - sync store on full cell stalls
// R7 - store filling cell sets full
// R8 - try load on empty returns zero
// R9 - try store on full silently dropped
// R10 - store-conditional reports try-store success
// R11 - threads ignore store-conditional elsewhere
// R12 - sync semaphore load stalls at zero
// R13 - semaphore load returns count, decrements
// R14 - try semaphore load skips zero decrement
// R15 - semaphore store increments, saturates 0xFFFF
// R16 - semaphore store never stalls
// R17 - semaphore views leave flags alone
// R18 - software clears flags before semaphore use
// R19 - reserved codes behave as bypass
// R20 - 1111 accesses unit control register
// R21 - multi-entry cells are first in first out
// R22 - threads use semaphores on single-entry only
// R23 - bypass reads head, writes tail
// R24 - full means valid data or max entries
// R25 - stalled requests retry until condition clears
module tcv_top #(
  parameter int unsigned CELLS = 8,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic        core_clk_i,
  input  wire logic        rstn_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic             pready_o,
  output logic [31:0]      prdata_o,
  output logic             pslverr_o,
  output logic             busy_o
);
  localparam int unsigned IDX_W = (CELLS > 1) ? $clog2(CELLS) : 1;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  tcv_req_if #(.IDX_W(IDX_W)) req ();
  tcv_pkg::tcv_state_t st_q, st_d;     // sequencer state
  logic [31:0] addr_q, addr_d;          // request address
  logic [31:0] wd_q, wd_d;              // request write data
  logic [1:0]  cmd_q, cmd_d;            // store, store-conditional
  logic        stl_q, stl_d;            // last attempt stalled
  logic        scok_q, scok_d;          // store-conditional outcome
  logic        fail_q, fail_d;          // try access failed
  logic [31:0] rdat_q, rdat_d;          // load data
  logic [31:0] ucr_q, ucr_d;            // unit_control_register
  logic        go_q, go_d;              // launch pulse to the cells
  logic        rdy_q, rdy_d;
  logic        err_q, err_d;
  logic [31:0] prd_q, prd_d;
  logic        busy_q, busy_d;          // request executing or retried
  logic        acc;

  assign acc = psel_i & penable_i & ~rdy_q;  // one-wait apb access phase

  assign req.go    = go_q;
  assign req.store = cmd_q[tcv_pkg::CMD_STORE_BIT];
  assign req.view  = addr_q[tcv_pkg::VIEW_MSB:tcv_pkg::VIEW_LSB];   // [R1]
  assign req.idx   = addr_q[tcv_pkg::CELL_LSB +: IDX_W];
  assign req.wdata = wd_q;

  // ------------------------------------------------------------
  // apb decode and request sequencer
  // ------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    addr_d = addr_q;
    wd_d = wd_q;
    cmd_d = cmd_q;
    stl_d = stl_q;
    scok_d = scok_q;
    fail_d = fail_q;
    rdat_d = rdat_q;
    ucr_d = ucr_q;
    go_d = 1'b0;
    rdy_d = acc;
    err_d = 1'b0;
    prd_d = prd_q;
    // writes to request registers are refused while busy
    if (acc && pwrite_i) begin
      case (paddr_i)
        tcv_pkg::REG_ADDR_OFS:  if (st_q == tcv_pkg::TCV_IDLE) addr_d = pwdata_i;
                                else err_d = 1'b1;
        tcv_pkg::REG_WDATA_OFS: if (st_q == tcv_pkg::TCV_IDLE) wd_d = pwdata_i;
                                else err_d = 1'b1;
        tcv_pkg::REG_CMD_OFS: begin
          if (st_q == tcv_pkg::TCV_IDLE) begin
            cmd_d = pwdata_i[1:0];
            go_d = 1'b1;
            st_d = tcv_pkg::TCV_EXEC;
          end else begin
            err_d = 1'b1;
          end
        end
        default: err_d = 1'b1;
      endcase
    end else if (acc) begin
      case (paddr_i)
        tcv_pkg::REG_ADDR_OFS:   prd_d = addr_q;
        tcv_pkg::REG_WDATA_OFS:  prd_d = wd_q;
        tcv_pkg::REG_CMD_OFS:    prd_d = {30'h0000_0000, cmd_q};
        tcv_pkg::REG_STATUS_OFS: prd_d = {28'h000_0000, fail_q, scok_q, stl_q,
                                          st_q != tcv_pkg::TCV_IDLE};
        tcv_pkg::REG_RDATA_OFS:  prd_d = rdat_q;
        default: begin
          prd_d = '0;
          err_d = 1'b1;
        end
      endcase
    end
    case (st_q)
      tcv_pkg::TCV_IDLE: ;
      tcv_pkg::TCV_EXEC: begin
        if (req.done) begin
          stl_d = req.stall;
          if (req.stall) begin
            st_d = tcv_pkg::TCV_WAIT;                     // retry later [R25]
          end else begin
            st_d = tcv_pkg::TCV_IDLE;
            rdat_d = req.rdata;
            fail_d = ~req.ok;
            // success only meaningful in the try view [R10]
            scok_d = cmd_q[tcv_pkg::CMD_SC_BIT] & req.ok &
                     (req.view == tcv_pkg::VIEW_EF_TRY);
            if (req.view == tcv_pkg::VIEW_UCR && req.store) begin
              ucr_d = req.wdata;                          // [R20]
            end
          end
        end
      end
      tcv_pkg::TCV_WAIT: begin
        // reissue every third cycle until another thread changes the cell
        go_d = 1'b1;                                      // [R25]
        st_d = tcv_pkg::TCV_EXEC;
      end
      default: st_d = tcv_pkg::TCV_IDLE;
    endcase
    busy_d = (st_d != tcv_pkg::TCV_IDLE);
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      st_q <= tcv_pkg::TCV_IDLE;
      addr_q <= '0;
      wd_q <= '0;
      cmd_q <= '0;
      stl_q <= 1'b0;
      scok_q <= 1'b0;
      fail_q <= 1'b0;
      rdat_q <= '0;
      ucr_q <= tcv_pkg::UCR_RESET;
      go_q <= 1'b0;
      rdy_q <= 1'b0;
      err_q <= 1'b0;
      prd_q <= '0;
      busy_q <= 1'b0;
    end else begin
      st_q <= st_d;
      addr_q <= addr_d;
      wd_q <= wd_d;
      cmd_q <= cmd_d;
      stl_q <= stl_d;
      scok_q <= scok_d;
      fail_q <= fail_d;
      rdat_q <= rdat_d;
      ucr_q <= ucr_d;
      go_q <= go_d;
      rdy_q <= rdy_d;
      err_q <= err_d;
      prd_q <= prd_d;
      busy_q <= busy_d;
    end
  end

  // ------------------------------------------------------------
  // cell array
  // ------------------------------------------------------------
  tcv_cells #(
    .CELLS (CELLS),
    .DEPTH (DEPTH),
    .IDX_W (IDX_W)
  ) u_cells (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .ucr_i      (ucr_q),
    .req        (req)
  );

  // outputs straight from flops
  assign pready_o  = rdy_q;
  assign pslverr_o = err_q;
  assign prdata_o  = prd_q;
  assign busy_o    = busy_q;
endmodule : tcv_top

/* rtl/tcv_pkg.sv */
// package for the thread cell view decoder: view codes, cell state layout,
// apb map and widths.
// assumes a single 50 MHz core clock and a synchronous active-low reset.
package tcv_pkg;

  // ------------------------------------------------------------
  // view codes, taken from physical address bits 6:3
  // ------------------------------------------------------------
  localparam int unsigned VIEW_LSB = 3;  // lowest view bit of the address
  localparam int unsigned VIEW_MSB = 6;  // highest view bit of the address
  localparam logic [3:0] VIEW_BYPASS  = 4'h0;
  localparam logic [3:0] VIEW_CONTROL = 4'h1;
  localparam logic [3:0] VIEW_EF_SYNC = 4'h2;
  localparam logic [3:0] VIEW_EF_TRY  = 4'h3;
  localparam logic [3:0] VIEW_PV_SYNC = 4'h4;
  localparam logic [3:0] VIEW_PV_TRY  = 4'h5;
  localparam logic [3:0] VIEW_UCR     = 4'hF;
  localparam int unsigned CELL_LSB    = 7;  // cell index starts above the view

  // ------------------------------------------------------------
  // cell state word layout (low 32 bits seen over apb)
  // ------------------------------------------------------------
  localparam int unsigned ST_EMPTY_BIT = 0;
  localparam int unsigned ST_FULL_BIT  = 1;
  localparam int unsigned ST_TYPE_BIT  = 17;
  localparam int unsigned ST_PTR_LSB   = 18;
  localparam int unsigned ST_DEPTH_LSB = 28;

  // ------------------------------------------------------------
  // apb register map of the block
  // ------------------------------------------------------------
  localparam logic [11:0] REG_ADDR_OFS   = 12'h000;  // request address
  localparam logic [11:0] REG_WDATA_OFS  = 12'h004;  // request write data
  localparam logic [11:0] REG_CMD_OFS    = 12'h008;  // write launches request
  localparam logic [11:0] REG_STATUS_OFS = 12'h00C;  // outcome of last request
  localparam logic [11:0] REG_RDATA_OFS  = 12'h010;  // load return data
  localparam int unsigned CMD_STORE_BIT  = 0;  // 1 store, 0 load
  localparam int unsigned CMD_SC_BIT     = 1;  // store-conditional flavour
  localparam int unsigned STS_BUSY_BIT   = 0;
  localparam int unsigned STS_STALL_BIT  = 1;
  localparam int unsigned STS_SC_OK_BIT  = 2;
  localparam int unsigned STS_FAIL_BIT   = 3;

  localparam logic [15:0] SEM_MAX = 16'hFFFF;  // semaphore saturation point
  localparam logic [31:0] UCR_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    TCV_IDLE,
    TCV_EXEC,
    TCV_WAIT
  } tcv_state_t;

endpackage : tcv_pkg

/* rtl/tcv_req_if.sv */
// request carrier between the decoder and its cell array.
// assumes both ends on the core clock.
`timescale 1ns/1ps
interface tcv_req_if #(
  parameter int unsigned IDX_W = 3
);
  logic             go;      // one-cycle request pulse
  logic             store;   // 1 store, 0 load
  logic [3:0]       view;    // decoded view code
  logic [IDX_W-1:0] idx;     // target cell
  logic [31:0]      wdata;   // store data
  logic             done;    // one-cycle completion pulse
  logic             stall;   // request must be retried
  logic             ok;      // store accepted / load succeeded
  logic [31:0]      rdata;   // load data

  modport master (output go, store, view, idx, wdata, input done, stall, ok, rdata);
  modport slave  (input go, store, view, idx, wdata, output done, stall, ok, rdata);
endinterface : tcv_req_if

/* rtl/tcv_cells.sv */
// cell array: data entries, empty/full flags and fifo pointers per cell.
// assumes requests arrive one at a time from the decoder.
`timescale 1ns/1ps
module tcv_cells #(
  parameter int unsigned CELLS = 8,
  parameter int unsigned DEPTH = 4,   // entries per cell, power of two
  parameter int unsigned IDX_W = 3
) (
  input  wire logic core_clk_i,
  input  wire logic rstn_i,
  input  wire logic [31:0] ucr_i,     // control register for view 1111
  tcv_req_if.slave  req
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  logic [31:0] mem_q [CELLS][DEPTH];   // entry data
  logic [31:0] mem_d [CELLS][DEPTH];
  logic [PW:0] cnt_q [CELLS];          // entries held
  logic [PW:0] cnt_d [CELLS];
  logic [PW-1:0] rp_q [CELLS];         // oldest entry pointer
  logic [PW-1:0] rp_d [CELLS];
  logic        done_q, done_d, stall_q, stall_d, ok_q, ok_d;
  logic [31:0] rd_q, rd_d;

  // ------------------------------------------------------------
  // request execution
  // ------------------------------------------------------------
  always_comb begin
    logic [PW-1:0] wp;
    logic [PW:0]   n;
    logic [15:0]   sem;
    logic          empty, full;
    mem_d = mem_q;
    cnt_d = cnt_q;
    rp_d  = rp_q;
    done_d = 1'b0;
    stall_d = 1'b0;
    ok_d = 1'b0;
    rd_d = rd_q;
    n     = cnt_q[req.idx];
    wp    = PW'(rp_q[req.idx] + PW'(n - 1'b1));   // tail = newest entry
    empty = (n == '0);
    full  = (n == DEPTH_C);  // full when every entry holds data [R24]
    sem   = mem_q[req.idx][rp_q[req.idx]][15:0];
    if (req.go) begin
      done_d = 1'b1;
      ok_d   = 1'b1;
      case (req.view)                                           // [R1]
        tcv_pkg::VIEW_CONTROL: begin                            // [R3]
          if (req.store) begin
            // the written full bit alone sets the entry count
            cnt_d[req.idx] = req.wdata[tcv_pkg::ST_FULL_BIT] ? DEPTH_C : '0;
            rp_d[req.idx]  = '0;
          end else begin
            rd_d = '0;
            rd_d[tcv_pkg::ST_EMPTY_BIT] = empty;
            rd_d[tcv_pkg::ST_FULL_BIT]  = full;
            rd_d[tcv_pkg::ST_TYPE_BIT]  = (DEPTH > 1);
            rd_d[tcv_pkg::ST_PTR_LSB +: PW] = rp_q[req.idx];
            rd_d[tcv_pkg::ST_DEPTH_LSB +: 2] = 2'(PW - ((DEPTH > 1) ? 0 : 1));
          end
        end
        tcv_pkg::VIEW_EF_SYNC, tcv_pkg::VIEW_EF_TRY: begin
          if (!req.store) begin
            if (empty) begin
              ok_d = 1'b0;
              rd_d = '0;                                        // [R8]
              stall_d = (req.view == tcv_pkg::VIEW_EF_SYNC);    // [R4]
            end else begin
              rd_d = mem_q[req.idx][rp_q[req.idx]];             // oldest first [R21]
              rp_d[req.idx] = (DEPTH > 1) ? PW'(rp_q[req.idx] + 1'b1) : '0;
              cnt_d[req.idx] = n - 1'b1;                        // empty at zero [R5]
            end
          end else if (full) begin
            ok_d = 1'b0;                                        // silent drop [R9]
            stall_d = (req.view == tcv_pkg::VIEW_EF_SYNC);      // [R6]
          end else begin
            mem_d[req.idx][PW'(rp_q[req.idx] + PW'(n))] = req.wdata;
            cnt_d[req.idx] = n + 1'b1;                          // full at depth [R7]
          end
        end
        tcv_pkg::VIEW_PV_SYNC, tcv_pkg::VIEW_PV_TRY: begin     // flags untouched [R17]
          if (!req.store) begin
            rd_d = {16'h0000, sem};                             // [R13]
            if (sem != 16'h0000) begin
              mem_d[req.idx][rp_q[req.idx]][15:0] = sem - 16'h0001;
            end else if (req.view == tcv_pkg::VIEW_PV_SYNC) begin
              stall_d = 1'b1;                                   // [R12]
              ok_d = 1'b0;
            end                                                 // try: no decrement [R14]
          end else if (sem != tcv_pkg::SEM_MAX) begin           // never stalls [R16]
            mem_d[req.idx][rp_q[req.idx]][15:0] = sem + 16'h0001;  // saturating [R15]
          end
        end
        tcv_pkg::VIEW_UCR: begin                                // [R20]
          if (!req.store) rd_d = ucr_i;
        end
        default: begin  // bypass and reserved codes [R2] [R19]
          if (req.store) begin
            mem_d[req.idx][empty ? rp_q[req.idx] : wp] = req.wdata;  // tail [R23]
          end else begin
            rd_d = mem_q[req.idx][rp_q[req.idx]];               // head [R23]
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      for (int c = 0; c < CELLS; c++) begin
        for (int e = 0; e < DEPTH; e++) mem_q[c][e] <= '0;
        cnt_q[c] <= '0;
        rp_q[c]  <= '0;
      end
      done_q <= 1'b0;
      stall_q <= 1'b0;
      ok_q <= 1'b0;
      rd_q <= '0;
    end else begin
      mem_q <= mem_d;
      cnt_q <= cnt_d;
      rp_q  <= rp_d;
      done_q <= done_d;
      stall_q <= stall_d;
      ok_q <= ok_d;
      rd_q <= rd_d;
    end
  end

  assign req.done  = done_q;
  assign req.stall = stall_q;
  assign req.ok    = ok_q;
  assign req.rdata = rd_q;
endmodule : tcv_cells

/* sim/tcv_thread_model.sv */
// apb master standing in for the core threads that issue requests.
// assumes the slave answers with pready on the core clock.
`timescale 1ns/1ps
module tcv_thread_model (
  input  wire logic        core_clk_i,
  input  wire logic        pready_i,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pslverr_i,
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic [11:0]      paddr_o,
  output logic [31:0]      pwdata_o
);
  // ---------------------------------------------------------
  // idle bus at time zero
  // ---------------------------------------------------------
  initial begin
    psel_o    = 1'b0;
    penable_o = 1'b0;
    pwrite_o  = 1'b0;
    paddr_o   = 12'h000;
    pwdata_o  = 32'h0;
  end
  // ---------------------------------------------------------
  // one transfer: setup, access held until pready or 16 cycles, release
  // ---------------------------------------------------------
  // no thread leans on sc results outside the try view
  // semaphore views only go to single-entry cells
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] r, output logic e, output logic to);
    to = 1'b1;
    @(posedge core_clk_i);
    psel_o   <= 1'b1;
    pwrite_o <= w;
    paddr_o  <= a;
    pwdata_o <= wd;
    @(posedge core_clk_i);
    penable_o <= 1'b1;
    for (int n = 0; n < 16 && to; n++) begin
      @(posedge core_clk_i);
      if (pready_i === 1'b1) begin
        r  = prdata_i;
        e  = pslverr_i;
        to = 1'b0;
      end
    end
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
    // released data flips so stale values are never mistaken
    pwdata_o  <= ~wd;
  endtask : xfer
endmodule : tcv_thread_model

/* sim/tcv_top_assertions.sv */
// checker for the decoder top: handshake, refusals, request timing.
// assumes the view is written before each launch.
`timescale 1ns/1ps
module tcv_top_assertions (
  input wire logic        core_clk_i,
  input wire logic        rstn_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        pready_o,
  input wire logic [31:0] prdata_o,
  input wire logic        pslverr_o,
  input wire logic        busy_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  // ---------------------------------------------------------
  // helper: view of the last accepted address write
  // ---------------------------------------------------------
  logic [3:0] view_d;  // next view
  logic [3:0] view_q;  // view used by the next launch
  logic       take;    // first access edge of a transfer
  assign take = psel_i && penable_i && !pready_o;
  always_comb begin
    view_d = view_q;
    if (pready_o && pwrite_i && !pslverr_o && paddr_i == tcv_pkg::REG_ADDR_OFS) begin
      view_d = pwdata_i[6:3];
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      view_q <= 4'h0;
    end else begin
      view_q <= view_d;
    end
  end
  // ---------------------------------------------------------
  // launch and completion steps
  // ---------------------------------------------------------
  sequence s_launch;
    take && pwrite_i && !busy_o && paddr_i == tcv_pkg::REG_CMD_OFS;
  endsequence
  sequence s_done;
    ##[2:6] !busy_o;
  endsequence
  chk_one_wait: assert property (take |=> pready_o)
    else $error("pready not one cycle after access");
  chk_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("pready longer than one cycle");
  chk_ready_access: assert property (pready_o |-> psel_i && penable_i)
    else $error("pready outside access phase");
  chk_unmapped_err: assert property (take && !pwrite_i && paddr_i > 12'h010
    |=> pslverr_o && prdata_o == 32'h0)
    else $error("unmapped read not refused");
  chk_busy_refuse: assert property (take && pwrite_i && busy_o && paddr_i <= 12'h008
    |=> pslverr_o)
    else $error("write while busy not refused");
  chk_launch_busy: assert property (s_launch |=> busy_o && pready_o && !pslverr_o)
    else $error("launch did not start");
  chk_view_nonblock: assert property (
    s_launch ##0 (view_q != 4'h2 && view_q != 4'h4) |-> s_done)
    else $error("non-blocking view stalled");
  chk_sem_store: assert property (
    s_launch ##0 (view_q == 4'h4 && pwdata_i[0]) |-> s_done)
    else $error("semaphore store stalled");
  chk_status_busy: assert property (take && !pwrite_i && busy_o
    && paddr_i == tcv_pkg::REG_STATUS_OFS |=> prdata_o[0])
    else $error("status hides busy");
endmodule : tcv_top_assertions
bind tcv_top tcv_top_assertions i_tcv_top_assertions (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
  .prdata_o(prdata_o), .pslverr_o(pslverr_o), .busy_o(busy_o));

/* sim/testbench.sv */
// self-checking bench: requests go through the thread model over apb
// and are compared with a cell model kept here (single-entry cells).
`timescale 1ns/1ps
module testbench;
  // ---------------------------------------------------------
  // signals and model state
  // ---------------------------------------------------------
  logic        core_clk_i, rstn_i;
  logic        psel, penable, pwrite, pready, pslverr, busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, m_ucr;
  logic [31:0] m_data [8];       // one entry per cell
  logic        m_emp [8];        // empty flags
  logic        m_full [8];       // full flags
  logic        er;
  logic [3:0]  sts;
  int          n_mismatch, comparisons;
  integer      seed;
  always #10 core_clk_i = ~core_clk_i;
  // depth 1 keeps every cell legal for the semaphore views
  tcv_top #(.CELLS(8), .DEPTH(1)) i_tcv_top (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
    .prdata_o(prdata), .pslverr_o(pslverr), .busy_o(busy));
  tcv_thread_model i_tcv_thread_model (
    .core_clk_i(core_clk_i), .pready_i(pready), .prdata_i(prdata), .pslverr_i(pslverr),
    .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
    .pwdata_o(pwdata));
  // ---------------------------------------------------------
  // report and compare
  // ---------------------------------------------------------
  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim
  task automatic cmp_data(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) begin
      n_mismatch++;
      $display("ERROR t=%0t data got %h exp %h", $time, g, x);
    end
  endtask : cmp_data
  task automatic cmp_sts(input logic [3:0] g, input logic [3:0] x, input logic [3:0] m);
    comparisons++;
    if ((g & m) !== (x & m)) begin
      n_mismatch++;
      $display("ERROR t=%0t status got %h exp %h", $time, g, x);
    end
  endtask : cmp_sts
  // ---------------------------------------------------------
  // bus access; a hung slave ends the run
  // ---------------------------------------------------------
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] r, output logic e);
    logic to;
    i_tcv_thread_model.xfer(w, a, wd, r, e, to);
    if (to !== 1'b0) begin
      n_mismatch++;
      end_sim();
    end
  endtask : bus
  // address, data, command, poll status, fetch load data
  task automatic launch(input logic [3:0] v, input int c, input logic [1:0] cmd,
                        input logic [31:0] wd, output logic [31:0] r, output logic [3:0] s);
    logic e;
    bus(1'b1, tcv_pkg::REG_ADDR_OFS, (32'(c) << tcv_pkg::CELL_LSB) | {25'h0, v, 3'h0}, r, e);
    bus(1'b1, tcv_pkg::REG_WDATA_OFS, wd, r, e);
    bus(1'b1, tcv_pkg::REG_CMD_OFS, {30'h0, cmd}, r, e);
    s = 4'hF;
    for (int k = 0; k < 12 && s[0] !== 1'b0; k++) begin
      bus(1'b0, tcv_pkg::REG_STATUS_OFS, 32'h0, r, e);
      s = r[3:0];
    end
    bus(1'b0, tcv_pkg::REG_RDATA_OFS, 32'h0, r, e);
  endtask : launch
  // ---------------------------------------------------------
  // cell model; cmd bit0 store, bit1 store-conditional
  // ---------------------------------------------------------
  task automatic model(input logic [3:0] v, input int c, input logic [1:0] cmd,
                       input logic [31:0] wd, output logic [31:0] x, output logic [3:0] xs);
    x  = 32'h0;
    xs = 4'h0;
    case (v)
      4'h1: begin  // state word
        x = {30'h0, m_full[c], m_emp[c]};
        if (cmd[0]) begin
          m_full[c] = wd[1];
          m_emp[c]  = !wd[1];
        end
      end
      4'h2, 4'h3: begin  // failed try keeps state, load gives 0
        if (cmd[0] ? m_full[c] : m_emp[c]) begin
          xs[3] = 1'b1;
        end else if (cmd[0]) begin
          m_data[c] = wd;
          m_full[c] = 1'b1;
          m_emp[c]  = 1'b0;
          xs[2]     = cmd[1];
        end else begin
          x         = m_data[c];
          m_emp[c]  = 1'b1;
          m_full[c] = 1'b0;
        end
      end
      4'h4, 4'h5: begin  // count in low 16 bits
        x = {16'h0, m_data[c][15:0]};
        if (cmd[0] && m_data[c][15:0] != tcv_pkg::SEM_MAX) begin
          m_data[c][15:0] = m_data[c][15:0] + 16'h1;
        end else if (!cmd[0] && m_data[c][15:0] != 16'h0) begin
          m_data[c][15:0] = m_data[c][15:0] - 16'h1;
        end
      end
      4'hF: begin
        x = m_ucr;
        if (cmd[0]) begin
          m_ucr = wd;
        end
      end
      default: begin  // bypass and reserved codes
        x = m_data[c];
        if (cmd[0]) begin
          m_data[c] = wd;
        end
      end
    endcase
  endtask : model
  task automatic req(input logic [3:0] v, input int c, input logic [1:0] cmd,
                     input logic [31:0] wd);
    logic [31:0] r, x;
    logic [3:0]  s, xs;
    model(v, c, cmd, wd, x, xs);
    launch(v, c, cmd, wd, r, s);
    cmp_sts(s, xs, (v != 4'h3) ? 4'h3 : (cmd[1] ? 4'hF : 4'hB));
    if (!cmd[0]) begin
      cmp_data(r, x);
    end
  endtask : req
  // ---------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------
  initial begin
    core_clk_i  = 1'b0;
    rstn_i      = 1'b0;
    n_mismatch  = 0;
    comparisons = 0;
    seed        = 32'hA4FB3C2E;
    repeat (4) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    m_ucr = tcv_pkg::UCR_RESET;
    req(4'hF, 0, 2'h0, 32'h0);
    req(4'hF, 0, 2'h1, $random(seed));
    req(4'hF, 0, 2'h0, 32'h0);
    for (int c = 0; c < 8; c++) begin
      req(4'h1, c, 2'h1, 32'h0);
      req(4'h1, c, 2'h0, 32'h0);
    end
    for (int v = 0; v < 15; v++) begin
      if (v == 0 || v > 5) begin
        req(4'(v), 1, 2'h1, $random(seed));
        req(4'(v), 1, 2'h0, 32'h0);
        req(4'h1, 1, 2'h0, 32'h0);
      end
    end
    req(4'h3, 2, 2'h0, 32'h0);
    req(4'h2, 2, 2'h1, $random(seed));
    req(4'h1, 2, 2'h0, 32'h0);
    req(4'h3, 2, 2'h3, $random(seed));
    req(4'h3, 2, 2'h0, 32'h0);
    req(4'h3, 2, 2'h3, $random(seed));
    req(4'h2, 2, 2'h0, 32'h0);
    req(4'h1, 2, 2'h0, 32'h0);
    req(4'h0, 3, 2'h1, 32'h0000FFFE);
    req(4'h4, 3, 2'h1, $random(seed));
    req(4'h5, 3, 2'h1, $random(seed));
    req(4'h4, 3, 2'h0, 32'h0);
    req(4'h1, 3, 2'h0, 32'h0);
    req(4'h0, 3, 2'h1, 32'h00000001);
    repeat (3) req(4'h5, 3, 2'h0, 32'h0);
    // stalled sync load, then stalled sync store; reset frees each
    for (int s = 0; s < 2; s++) begin
      req(4'h1, 4, 2'h1, 32'h0);
      if (s == 1) begin
        req(4'h2, 4, 2'h1, $random(seed));
      end
      launch(4'h2, 4, 2'(s), 32'h0, rd, sts);
      cmp_sts(sts, 4'h3, 4'h3);
      bus(1'b1, tcv_pkg::REG_CMD_OFS, 32'h0, rd, er);
      cmp_sts({3'h0, er}, 4'h1, 4'h1);
      bus(1'b0, 12'h020, 32'h0, rd, er);
      cmp_sts({3'h0, er}, 4'h1, 4'h1);
      cmp_data(rd, 32'h0);
      @(posedge core_clk_i);
      rstn_i <= 1'b0;
      repeat (4) @(posedge core_clk_i);
      rstn_i <= 1'b1;
      m_ucr = tcv_pkg::UCR_RESET;
      req(4'hF, 0, 2'h0, 32'h0);
    end
    end_sim();
  end
endmodule : testbench
